/* logic/scpl_consts.svh */
`ifndef SCPL_CONSTS_SVH
`define SCPL_CONSTS_SVH

`define SCPL_NCH          6
`define SCPL_CLK_HZ       20000000
`define SCPL_CLK_NS       50
`define SCPL_FILT_NS      50000
`define SCPL_FILT_CYC     ((`SCPL_FILT_NS + `SCPL_CLK_NS - 1) / `SCPL_CLK_NS)
`define SCPL_PWM_HZ       62500
`define SCPL_PWM_BITS     6
`define SCPL_PWM_STEP_CYC ((`SCPL_CLK_HZ / `SCPL_PWM_HZ) >> `SCPL_PWM_BITS)
`define SCPL_DUTY_FULL    7'h40
`define SCPL_BOOT_CYC     4

`define SCPL_A_CTRL       4'h0
`define SCPL_A_REQ_ON     4'h1
`define SCPL_A_GROUP      4'h2
`define SCPL_A_POL        4'h3
`define SCPL_A_DRIVE      4'h4
`define SCPL_A_MARGIN     4'h5
`define SCPL_A_STATUS     4'h6
`define SCPL_A_MASK       4'h7
`define SCPL_A_FAULT      4'h8
`define SCPL_A_PINS       4'h9
`define SCPL_A_DUTY0      4'hA

`define SCPL_CTRL_USE     0
`define SCPL_CTRL_HIGH    1
`define SCPL_CTRL_RST     2'h0
`define SCPL_POL_RST      6'h3F
`define SCPL_ST_LINE      0
`define SCPL_ST_OWN       1
`define SCPL_ST_CTLOFF    2
`define SCPL_ST_PGUP      3

`endif

/* logic/scpl_pkg.sv */
package scpl_pkg;

   typedef struct packed {
      logic o;
      logic oe;
   } scpl_pin_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } scpl_bus_t;

   typedef enum logic [1:0] {SCPL_BOOT, SCPL_SAMPLE, SCPL_RUN} scpl_phase_t;

   // pin drive: open drain only ever pulls low, push-pull drives both levels
   function automatic scpl_pin_t scpl_drive(input logic run, input logic od, input logic lvl);
      scpl_pin_t p;
      p.o  = 1'b0;
      p.oe = 1'b0;
      if (run && od) begin
         p.oe = ~lvl;
      end else if (run) begin
         p.o  = lvl;
         p.oe = 1'b1;
      end
      return p;
   endfunction : scpl_drive

endpackage : scpl_pkg

/* logic/scpl_deglitch.sv */
`timescale 1ns/1ns
module scpl_deglitch #(
   parameter int   CNT     = 1000,
   parameter logic RST_VAL = 1'b1
) (
   input  logic i_clk,
   input  logic i_reset,
   input  logic i_pin,
   output logic o_level
);
   localparam int         W    = $clog2(CNT + 1);
   localparam logic [W-1:0] LAST = W'(CNT - 1);

   logic [1:0]   sync_ff;
   logic [W-1:0] cnt_ff;
   logic         level_ff;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sync_ff <= {2{RST_VAL}};
      end else begin
         sync_ff <= {sync_ff[0], i_pin};
      end
   end

   // a new level is taken only after it stood for the whole filter time
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         cnt_ff   <= '0;
         level_ff <= RST_VAL;
      end else if (sync_ff[1] == level_ff) begin
         cnt_ff <= '0;
      end else if (cnt_ff == LAST) begin
         cnt_ff   <= '0;
         level_ff <= sync_ff[1];
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   assign o_level = level_ff;

   filt_hold_a : assert property (@(posedge i_clk) disable iff (i_reset)
      $changed(level_ff) |-> $past(cnt_ff) == LAST && $past(sync_ff[1]) == level_ff)
      else $error("filtered level changed before the filter time");

endmodule : scpl_deglitch

/* logic/scpl_margin_pwm.sv */
`timescale 1ns/1ns
`include "scpl_consts.svh"
module scpl_margin_pwm
   import scpl_pkg::*;
(
   input  logic      i_clk,
   input  logic      i_reset,
   input  logic      i_run,
   input  logic      i_en,
   input  logic [6:0] i_duty,
   input  logic [5:0] i_pos,
   output scpl_pin_t o_pin
);
   scpl_pin_t pin_ff;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         pin_ff <= '0;
      end else if (!i_run || !i_en) begin
         pin_ff <= '0;
      end else if (i_duty >= `SCPL_DUTY_FULL) begin
         pin_ff <= '{o: 1'b1, oe: 1'b1};
      end else begin
         pin_ff <= '{o: (i_pos < i_duty[5:0]), oe: 1'b1};
      end
   end

   assign o_pin = pin_ff;

   pwm_off_a : assert property (@(posedge i_clk) disable iff (i_reset)
      !$past(i_en) |-> !pin_ff.oe && !pin_ff.o)
      else $error("margin pin driven while margining off");

   pwm_full_a : assert property (@(posedge i_clk) disable iff (i_reset)
      $past(i_run && i_en && i_duty >= `SCPL_DUTY_FULL) |-> pin_ff.o && pin_ff.oe)
      else $error("full duty margin pin not held high");

endmodule : scpl_margin_pwm

/* logic/scpl_pin_ctrl.sv */
`timescale 1ns/1ns
`include "scpl_consts.svh"
// Functional notes
// - margin pin floats when margining off
// - full duty holds margin pin high
// - per-channel enable polarity select
// - per-channel open-drain or push-pull select
// - sample address pins at power-up
// - address pin zero becomes mux select
// - mux select low voltage, high current
// - pull fault line on group fault
// - fault line low shuts group supplies
// - fault line wired among peer managers
// - fault line released during reset
// - fault and control inputs deglitched
// - control input polarity per config
// - address pin one becomes power good
// - alert is active-low open drain
// - reset pin active low
// - pins float with pullup during reset
module scpl_pin_ctrl
   import scpl_pkg::*;
#(
   parameter int FILT_CYC = `SCPL_FILT_CYC,
   parameter int STEP_CYC = `SCPL_PWM_STEP_CYC,
   parameter int BOOT_CYC = `SCPL_BOOT_CYC
) (
   input  logic            i_clk,
   input  logic            i_reset,
   input  logic            i_rst_pin_n,
   input  scpl_bus_t       i_bus,
   output logic [15:0]     o_rdata,
   output logic            o_irq,
   input  logic [5:0]      i_supply_fault,
   input  logic [5:0]      i_above_pg_on,
   input  logic            i_meas_current,
   input  logic            i_addr_bit0_or_meas_select,
   input  logic            i_addr_bit1_or_supplies_good,
   input  logic            i_fault_line,
   input  logic            i_control_pin,
   output scpl_pin_t       o_meas_select_out,
   output scpl_pin_t       o_supplies_good_out,
   output scpl_pin_t       o_fault_line,
   output scpl_pin_t       o_alert,
   output scpl_pin_t [5:0] o_margin_pwm_out,
   output scpl_pin_t [5:0] o_supply_enable_out,
   output logic            o_weak_pullup,
   output logic [1:0]      o_bus_address
);
   localparam int BW = $clog2(BOOT_CYC + 1);
   localparam int SW = $clog2(STEP_CYC + 1);

   logic [1:0]      rstp_ff, a0_s_ff, a1_s_ff, bus_addr_ff, ctrl_ff;
   scpl_phase_t     phase_ff;
   logic [BW-1:0]   boot_cnt_ff;
   logic [SW-1:0]   div_ff;
   logic            run_ff, hold, line_lvl, ctl_lvl, line_q_ff, ctl_ok_q_ff, ctl_ok, pg_now, wr_hit, rd_status;
   logic [5:0]      req_on_ff, group_ff, pol_ff, od_ff, mgn_en_ff, own_flt_ff, ext_shut_ff, ch_on, pos_ff;
   logic [6:0]      duty_ff [6];
   logic [3:0]      status_ff, mask_ff, st_set;
   scpl_pin_t [5:0] sen_ff;
   scpl_pin_t       meas_ff, pg_ff, fault_ff, alert_ff;
   logic [15:0]     rd_mux, rdata_ff;

   // ---- reset pin and address straps, all pins come from outside
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rstp_ff <= 2'h0;
         a0_s_ff <= 2'h0;
         a1_s_ff <= 2'h0;
      end else begin
         rstp_ff <= {rstp_ff[0], i_rst_pin_n};
         a0_s_ff <= {a0_s_ff[0], i_addr_bit0_or_meas_select};
         a1_s_ff <= {a1_s_ff[0], i_addr_bit1_or_supplies_good};
      end
   end

   assign hold = ~rstp_ff[1];

   // ---- power-up phase: float with pullup, sample straps, then run
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         phase_ff    <= SCPL_BOOT;
         boot_cnt_ff <= '0;
      end else if (hold) begin
         phase_ff    <= SCPL_BOOT;
         boot_cnt_ff <= '0;
      end else begin
         unique case (phase_ff)
            SCPL_BOOT: begin
               if (boot_cnt_ff == BW'(BOOT_CYC - 1)) begin
                  phase_ff <= SCPL_SAMPLE;
               end else begin
                  boot_cnt_ff <= boot_cnt_ff + 1'b1;
               end
            end
            SCPL_SAMPLE: begin
               phase_ff <= SCPL_RUN;
            end
            SCPL_RUN: begin
               phase_ff <= SCPL_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         run_ff <= 1'b0;
      end else begin
         run_ff <= !hold && (phase_ff != SCPL_BOOT);
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         bus_addr_ff <= 2'h0;
      end else if (phase_ff == SCPL_SAMPLE && !hold) begin
         bus_addr_ff <= {a1_s_ff[1], a0_s_ff[1]};
      end
   end

   assign o_bus_address = bus_addr_ff;
   assign o_weak_pullup = ~run_ff;

   // ---- deglitched fault line and control input
   scpl_deglitch #(.CNT(FILT_CYC), .RST_VAL(1'b1)) u_line_filt (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_pin   (i_fault_line),
      .o_level (line_lvl)
   );

   scpl_deglitch #(.CNT(FILT_CYC), .RST_VAL(1'b0)) u_ctl_filt (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_pin   (i_control_pin),
      .o_level (ctl_lvl)
   );

   // ---- channel on/off decision
   assign ctl_ok = !ctrl_ff[`SCPL_CTRL_USE] || (ctl_lvl == ctrl_ff[`SCPL_CTRL_HIGH]);
   assign ch_on  = req_on_ff & ~own_flt_ff & ~ext_shut_ff & {6{ctl_ok && run_ff}};
   assign pg_now = run_ff && (|ch_on) && (&(i_above_pg_on | ~ch_on));

   // own faults latch until software clears them; a new fault wins
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         own_flt_ff <= '0;
      end else begin
         own_flt_ff <= (own_flt_ff & ~({6{wr_hit && i_bus.addr == `SCPL_A_FAULT}} & i_bus.wdata[5:0]))
                       | (i_supply_fault & ch_on);
      end
   end

   // a low fault line keeps group channels off; clearing is refused while it stays low
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ext_shut_ff <= '0;
      end else begin
         ext_shut_ff <= (ext_shut_ff & ~({6{wr_hit && i_bus.addr == `SCPL_A_FAULT}} & i_bus.wdata[13:8]))
                        | (group_ff & {6{run_ff && !line_lvl}});
      end
   end

   // ---- margin pwm: 64 steps per period
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         div_ff <= '0;
         pos_ff <= 6'h00;
      end else if (div_ff == SW'(STEP_CYC - 1)) begin
         div_ff <= '0;
         pos_ff <= pos_ff + 1'b1;
      end else begin
         div_ff <= div_ff + 1'b1;
      end
   end

   for (genvar c = 0; c < `SCPL_NCH; c++) begin : g_pwm
      scpl_margin_pwm u_pwm (
         .i_clk   (i_clk),
         .i_reset (i_reset),
         .i_run   (run_ff),
         .i_en    (mgn_en_ff[c]),
         .i_duty  (duty_ff[c]),
         .i_pos   (pos_ff),
         .o_pin   (o_margin_pwm_out[c])
      );
   end

   // ---- pin drivers
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sen_ff <= '0;
      end else begin
         for (int c = 0; c < `SCPL_NCH; c++) begin
            sen_ff[c] <= scpl_drive(run_ff, od_ff[c], ch_on[c] ~^ pol_ff[c]);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meas_ff  <= '0;
         pg_ff    <= '0;
         fault_ff <= '0;
         alert_ff <= '0;
      end else begin
         meas_ff  <= scpl_drive(run_ff, 1'b0, i_meas_current);
         pg_ff    <= scpl_drive(run_ff, 1'b0, pg_now);
         fault_ff <= '{o: 1'b0, oe: !hold && run_ff && |(own_flt_ff & group_ff)};
         alert_ff <= '{o: 1'b0, oe: run_ff && |(status_ff & mask_ff)};
      end
   end

   assign o_supply_enable_out = sen_ff;
   assign o_meas_select_out   = meas_ff;
   assign o_supplies_good_out = pg_ff;
   assign o_fault_line        = fault_ff;
   assign o_alert             = alert_ff;

   // ---- register bus
   assign wr_hit    = i_bus.wr;
   assign rd_status = i_bus.rd && i_bus.addr == `SCPL_A_STATUS;

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         ctrl_ff   <= `SCPL_CTRL_RST;
         req_on_ff <= '0;
         group_ff  <= '0;
         pol_ff    <= `SCPL_POL_RST;
         od_ff     <= '0;
         mgn_en_ff <= '0;
         mask_ff   <= '0;
      end else if (wr_hit) begin
         case (i_bus.addr)
            `SCPL_A_CTRL:   ctrl_ff   <= i_bus.wdata[1:0];
            `SCPL_A_REQ_ON: req_on_ff <= i_bus.wdata[5:0];
            `SCPL_A_GROUP:  group_ff  <= i_bus.wdata[5:0];
            `SCPL_A_POL:    pol_ff    <= i_bus.wdata[5:0];
            `SCPL_A_DRIVE:  od_ff     <= i_bus.wdata[5:0];
            `SCPL_A_MARGIN: mgn_en_ff <= i_bus.wdata[5:0];
            `SCPL_A_MASK:   mask_ff   <= i_bus.wdata[3:0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int c = 0; c < `SCPL_NCH; c++) begin
            duty_ff[c] <= 7'h00;
         end
      end else if (wr_hit && i_bus.addr >= `SCPL_A_DUTY0) begin
         duty_ff[3'(i_bus.addr - `SCPL_A_DUTY0)] <= i_bus.wdata[6:0];
      end
   end

   // ---- sticky events; a new event beats the clearing read
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         line_q_ff   <= 1'b1;
         ctl_ok_q_ff <= 1'b0;
      end else begin
         line_q_ff   <= line_lvl;
         ctl_ok_q_ff <= ctl_ok;
      end
   end

   always_comb begin
      st_set                  = 4'h0;
      st_set[`SCPL_ST_LINE]   = run_ff && line_q_ff && !line_lvl;
      st_set[`SCPL_ST_OWN]    = |(i_supply_fault & ch_on & ~own_flt_ff);
      st_set[`SCPL_ST_CTLOFF] = run_ff && ctl_ok_q_ff && !ctl_ok;
      st_set[`SCPL_ST_PGUP]   = pg_now && !pg_ff.o;
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         status_ff <= 4'h0;
      end else begin
         status_ff <= (status_ff & ~{4{rd_status}}) | st_set;
      end
   end

   assign o_irq = |(status_ff & mask_ff);

   always_comb begin
      rd_mux = 16'h0000;
      case (i_bus.addr)
         `SCPL_A_CTRL:   rd_mux = {14'h0000, ctrl_ff};
         `SCPL_A_REQ_ON: rd_mux = {10'h000, req_on_ff};
         `SCPL_A_GROUP:  rd_mux = {10'h000, group_ff};
         `SCPL_A_POL:    rd_mux = {10'h000, pol_ff};
         `SCPL_A_DRIVE:  rd_mux = {10'h000, od_ff};
         `SCPL_A_MARGIN: rd_mux = {10'h000, mgn_en_ff};
         `SCPL_A_STATUS: rd_mux = {12'h000, status_ff};
         `SCPL_A_MASK:   rd_mux = {12'h000, mask_ff};
         `SCPL_A_FAULT:  rd_mux = {2'h0, ext_shut_ff, 2'h0, own_flt_ff};
         `SCPL_A_PINS:   rd_mux = {2'h0, ch_on, 1'b0, run_ff, ctl_lvl, line_lvl, 2'h0, bus_addr_ff};
         default:        rd_mux = {9'h000, duty_ff[3'(i_bus.addr - `SCPL_A_DUTY0)]};
      endcase
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         rdata_ff <= 16'h0000;
      end else if (i_bus.rd) begin
         rdata_ff <= rd_mux;
      end
   end

   assign o_rdata = rdata_ff;

   // ---- checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence boot_done_s;
      phase_ff == SCPL_SAMPLE && !hold ##1 run_ff;
   endsequence

   sen_pol_a : assert property (
      $past(run_ff && !od_ff[0]) |-> sen_ff[0].oe && sen_ff[0].o == $past(ch_on[0] ~^ pol_ff[0]))
      else $error("push-pull enable level does not follow polarity");
   sen_od_a : assert property (
      $past(od_ff[0]) |-> !sen_ff[0].o)
      else $error("open-drain enable drove high");
   addr_sample_a : assert property (
      boot_done_s |-> bus_addr_ff == $past({a1_s_ff[1], a0_s_ff[1]}))
      else $error("bus address not taken from straps");
   meas_sel_a : assert property (
      $past(run_ff) |-> meas_ff.oe && meas_ff.o == $past(i_meas_current))
      else $error("mux select does not show measurement kind");
   fault_drive_a : assert property (
      run_ff && !hold && |(own_flt_ff & group_ff) |=> fault_ff.oe && !fault_ff.o)
      else $error("group fault did not pull fault line");
   group_shut_a : assert property (
      run_ff && !hold && !line_lvl && group_ff[0] |=> !ch_on[0] ##1 sen_ff[0] == scpl_drive(1'b1, od_ff[0], ~pol_ff[0]))
      else $error("group supply not shut by fault line");
   fault_rel_a : assert property (
      hold |=> !fault_ff.oe)
      else $error("fault line held during reset");
   ctl_off_a : assert property (
      ctrl_ff[`SCPL_CTRL_USE] && ctl_lvl != ctrl_ff[`SCPL_CTRL_HIGH] |-> ch_on == 6'h00)
      else $error("control input off but a supply is on");
   pg_out_a : assert property (
      pg_ff.o |-> $past(run_ff && (&(i_above_pg_on | ~ch_on)) && |ch_on))
      else $error("power good high with a supply below threshold");
   alert_od_a : assert property (
      !alert_ff.o && (alert_ff.oe == $past(run_ff && o_irq)))
      else $error("alert not an open-drain low of the interrupt");
   rst_hold_a : assert property (
      hold |=> phase_ff == SCPL_BOOT ##1 !run_ff)
      else $error("low reset pin did not hold the block");
   boot_hiz_a : assert property (
      !$past(run_ff) |-> o_weak_pullup == !run_ff && !fault_ff.oe && !meas_ff.oe && sen_ff == '0)
      else $error("pin driven while in reset or power-up");

endmodule : scpl_pin_ctrl

/* test/scpl_far_side_model.sv */
`timescale 1ns/1ns
module scpl_far_side_model
   import scpl_pkg::*;
#(
   parameter logic [1:0] STRAPS = 2'h1
) (
   input  wire logic            i_clk,
   input  wire scpl_pin_t       i_fault_drive,
   input  wire scpl_pin_t [5:0] i_enable,
   input  wire scpl_pin_t       i_meas_sel,
   input  wire scpl_pin_t       i_good,
   input  wire logic [5:0]      i_pol,
   input  wire logic            i_peer_pull,
   input  wire logic            i_slow,
   output logic                 o_fault_wire,
   output logic [5:0]           o_above_pg_on,
   output logic                 o_pad0,
   output logic                 o_pad1
);
   logic [5:0] up_now;
   logic [5:0] up_dly [8];
   logic [5:0] up_all;
   // wired fault line with pull-up, any party may pull it low
   assign o_fault_wire = ~(i_fault_drive.oe | i_peer_pull);
   // strap resistors set the pads until the device drives them
   assign o_pad0 = i_meas_sel.oe ? i_meas_sel.o : STRAPS[0];
   assign o_pad1 = i_good.oe ? i_good.o : STRAPS[1];
   // a supply is up when its enable pad (pulled up when floating) shows the active level
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         up_now[i] = ((i_enable[i].oe ? i_enable[i].o : 1'b1) == i_pol[i]);
      end
   end
   // slow supplies report power good only after eight cycles up in a row
   always_ff @(posedge i_clk) begin
      up_dly[0] <= up_now;
      for (int i = 1; i < 8; i++) begin
         up_dly[i] <= up_dly[i-1];
      end
   end
   always_comb begin
      up_all = up_now;
      for (int i = 0; i < 8; i++) begin
         up_all = up_all & up_dly[i];
      end
   end
   assign o_above_pg_on = i_slow ? up_all : up_now;
endmodule : scpl_far_side_model

/* test/supply_control_pin_logic_tb_top.sv */
`timescale 1ns/1ns
`include "scpl_consts.svh"
module supply_control_pin_logic_tb_top;
   import scpl_pkg::*;
   localparam scpl_pin_t pin_float = 2'h0;
   localparam scpl_pin_t pin_low   = 2'h1;
   localparam scpl_pin_t pin_high  = 2'h3;
   logic            i_clk;
   logic            i_reset;
   logic            i_rst_pin_n;
   scpl_bus_t       i_bus;
   logic [15:0]     o_rdata;
   logic            o_irq;
   logic [5:0]      i_supply_fault;
   logic [5:0]      above;
   logic            i_meas_current;
   logic            pad0;
   logic            pad1;
   logic            fault_wire;
   logic            i_control_pin;
   scpl_pin_t       o_meas_select_out;
   scpl_pin_t       o_supplies_good_out;
   scpl_pin_t       o_fault_line;
   scpl_pin_t       o_alert;
   scpl_pin_t [5:0] o_margin_pwm_out;
   scpl_pin_t [5:0] o_supply_enable_out;
   logic            o_weak_pullup;
   logic [1:0]      o_bus_address;
   logic [5:0]      pol;
   logic            peer_pull;
   logic            slow;
   int              n_errors;
   int              cmp_count;
   int              bad;
   logic [15:0]     rv;

   scpl_pin_ctrl #(.FILT_CYC(4), .STEP_CYC(5), .BOOT_CYC(4)) u_dut (
      .i_clk(i_clk), .i_reset(i_reset), .i_rst_pin_n(i_rst_pin_n), .i_bus(i_bus), .o_rdata(o_rdata),
      .o_irq(o_irq), .i_supply_fault(i_supply_fault), .i_above_pg_on(above), .i_meas_current(i_meas_current),
      .i_addr_bit0_or_meas_select(pad0), .i_addr_bit1_or_supplies_good(pad1), .i_fault_line(fault_wire),
      .i_control_pin(i_control_pin), .o_meas_select_out(o_meas_select_out),
      .o_supplies_good_out(o_supplies_good_out), .o_fault_line(o_fault_line), .o_alert(o_alert),
      .o_margin_pwm_out(o_margin_pwm_out), .o_supply_enable_out(o_supply_enable_out),
      .o_weak_pullup(o_weak_pullup), .o_bus_address(o_bus_address));

   scpl_far_side_model #(.STRAPS(2'h1)) u_far (
      .i_clk(i_clk), .i_fault_drive(o_fault_line), .i_enable(o_supply_enable_out),
      .i_meas_sel(o_meas_select_out), .i_good(o_supplies_good_out), .i_pol(pol), .i_peer_pull(peer_pull),
      .i_slow(slow), .o_fault_wire(fault_wire), .o_above_pg_on(above), .o_pad0(pad0), .o_pad1(pad1));

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic chkp(input scpl_pin_t seen, input scpl_pin_t exp);
      chk({14'h0000, seen}, {14'h0000, exp});
   endtask : chkp

   function automatic scpl_pin_t exp_en(input logic on, input logic ah, input logic od);
      logic lvl;
      lvl = on ? ah : ~ah;
      return od ? (lvl ? pin_float : pin_low) : (lvl ? pin_high : pin_low);
   endfunction : exp_en

   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : cyc

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1;
      d = o_rdata;
   endtask : rd

   task automatic wait_run();
      for (int k = 0; k < 60; k++) begin
         if (o_weak_pullup === 1'b0) begin
            cyc(2);
            return;
         end
         cyc(1);
      end
      n_errors++;
      stop_test();
   endtask : wait_run

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      stop_test();
   end

   initial begin
      i_reset = 1'b1;
      i_rst_pin_n = 1'b1;
      i_bus = '0;
      i_supply_fault = 6'h00;
      i_meas_current = 1'b0;
      i_control_pin = 1'b0;
      pol = 6'h3F;
      peer_pull = 1'b0;
      slow = 1'b0;
      n_errors = 0;
      cmp_count = 0;
      cyc(3);
      chkp(o_fault_line, pin_float);
      chkp(o_supply_enable_out[0], pin_float);
      chkp(o_meas_select_out, pin_float);
      chk({15'h0000, o_weak_pullup}, 16'h0001);
      @(posedge i_clk);
      i_reset <= 1'b0;
      rd(`SCPL_A_POL, rv);
      chk(rv, 16'h003F);
      wait_run();
      chk({14'h0000, o_bus_address}, 16'h0001);
      chk({15'h0000, o_weak_pullup}, 16'h0000);
      // mux select follows the measurement kind
      i_meas_current <= 1'b1;
      cyc(3);
      chkp(o_meas_select_out, pin_high);
      i_meas_current <= 1'b0;
      cyc(3);
      chkp(o_meas_select_out, pin_low);
      // ch0 active low, ch1 open drain, ch0 and ch1 in the global group
      pol = 6'h3E;
      wr(`SCPL_A_POL, 16'h003E);
      wr(`SCPL_A_DRIVE, 16'h0002);
      wr(`SCPL_A_GROUP, 16'h0003);
      wr(`SCPL_A_MASK, 16'h0002);
      wr(`SCPL_A_REQ_ON, 16'h003F);
      cyc(4);
      for (int i = 0; i < 6; i++) begin
         chkp(o_supply_enable_out[i], exp_en(1'b1, pol[i], i == 1));
      end
      chkp(o_supplies_good_out, pin_high);
      slow = 1'b1;
      wr(`SCPL_A_REQ_ON, 16'h003B);
      cyc(3);
      chkp(o_supply_enable_out[2], exp_en(1'b0, 1'b1, 1'b0));
      wr(`SCPL_A_REQ_ON, 16'h003F);
      cyc(3);
      chkp(o_supplies_good_out, pin_low);
      cyc(10);
      chkp(o_supplies_good_out, pin_high);
      slow = 1'b0;
      // margin outputs
      chkp(o_margin_pwm_out[0], pin_float);
      wr(`SCPL_A_DUTY0, 16'h0040);
      wr(`SCPL_A_MARGIN, 16'h0001);
      cyc(2);
      bad = 0;
      for (int i = 0; i < 330; i++) begin
         cyc(1);
         bad += (o_margin_pwm_out[0] !== pin_high);
      end
      chk(16'(bad), 16'h0000);
      chkp(o_margin_pwm_out[1], pin_float);
      wr(`SCPL_A_MARGIN, 16'h0000);
      cyc(2);
      chkp(o_margin_pwm_out[0], pin_float);
      // short peer pulse is ignored, a long one shuts the group
      peer_pull <= 1'b1;
      cyc(2);
      peer_pull <= 1'b0;
      cyc(12);
      chkp(o_supply_enable_out[0], exp_en(1'b1, 1'b0, 1'b0));
      peer_pull <= 1'b1;
      cyc(12);
      peer_pull <= 1'b0;
      chkp(o_supply_enable_out[0], exp_en(1'b0, 1'b0, 1'b0));
      chkp(o_supply_enable_out[2], exp_en(1'b1, 1'b1, 1'b0));
      cyc(12);
      rd(`SCPL_A_STATUS, rv);
      chk({15'h0000, rv[0]}, 16'h0001);
      wr(`SCPL_A_FAULT, 16'h3F00);
      cyc(4);
      chkp(o_supply_enable_out[0], exp_en(1'b1, 1'b0, 1'b0));
      // own supply fault drives the shared line
      @(posedge i_clk);
      i_supply_fault <= 6'h01;
      @(posedge i_clk);
      i_supply_fault <= 6'h00;
      cyc(3);
      chkp(o_fault_line, pin_low);
      chkp(o_supply_enable_out[0], exp_en(1'b0, 1'b0, 1'b0));
      chk({15'h0000, o_irq}, 16'h0001);
      chkp(o_alert, pin_low);
      cyc(12);
      chkp(o_supply_enable_out[1], exp_en(1'b0, 1'b1, 1'b1));
      rd(`SCPL_A_STATUS, rv);
      chk({15'h0000, rv[1]}, 16'h0001);
      cyc(2);
      chkp(o_alert, pin_float);
      // control pin polarity and filtering
      wr(`SCPL_A_CTRL, 16'h0003);
      cyc(12);
      chkp(o_supply_enable_out[3], pin_low);
      i_control_pin <= 1'b1;
      cyc(12);
      chkp(o_supply_enable_out[3], pin_high);
      wr(`SCPL_A_CTRL, 16'h0001);
      cyc(4);
      chkp(o_supply_enable_out[3], pin_low);
      i_control_pin <= 1'b0;
      cyc(2);
      i_control_pin <= 1'b1;
      cyc(12);
      chkp(o_supply_enable_out[3], pin_low);
      // reset pin releases the still-latched fault drive
      i_rst_pin_n <= 1'b0;
      cyc(4);
      chkp(o_fault_line, pin_float);
      chk({15'h0000, o_weak_pullup}, 16'h0001);
      i_rst_pin_n <= 1'b1;
      wait_run();
      chkp(o_meas_select_out, pin_low);
      stop_test();
   end
endmodule : supply_control_pin_logic_tb_top
